/* rtl/dac_control_interface.sv */
/*
 * Register and pin control for the 8-bit digital-to-analog converter.
 * Assumes a byte register port with read data one cycle after the strobe,
 * a halt-mode level from the clock controller, and an analog ladder outside
 * that takes the code and the drive/open controls.
 */
// The plain strobed port is this design's own decision.
`include "dac_consts.svh"
`default_nettype none
module dac_control_interface
    import dac_pkg::*;
#(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output var  logic [7:0] rdata_o,
    input  wire logic       halt_i,
    input  wire logic       gpio_dir_out_i,
    input  wire logic       gpio_out_i,
    input  wire logic       shared_analog_pin_i,
    output var  logic       gpio_in_o,
    output var  logic [7:0] ladder_code_o,
    output var  logic       ladder_drive_o,
    output var  logic       pin_dir_out_o,
    output var  logic       pin_digital_out_o,
    output var  logic       pin_digital_oe_o,
    output var  logic       code_settled_o
);
    // the settle timer cannot serve counts below its checked bound
    if (SETTLE_CYCLES < 8) begin : g_bad_settle
        $error("dac_control_interface: SETTLE_CYCLES must be at least 8");
    end

    localparam byte_t CTRL_RESET = `CONV_CONTROL_RESET;

    // address decode used by both write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    byte_t     data_reg,    data_next;
    logic      enable_reg,  enable_next;
    byte_t     rdata_reg,   rdata_next;
    pin_mode_e mode_next;
    logic      drive_reg,   drive_next;
    logic      gin_reg,     gin_next;
    logic      dir_reg,     dir_next;
    logic      dout_reg,    dout_next;
    logic      doe_reg,     doe_next;
    logic      settled;

    // register writes; control accepts at any time, upper bits dropped
    always_comb begin
        data_next   = data_reg;
        enable_next = enable_reg;
        if (wr_i && hit(addr_i, `CONV_DATA_OFFSET)) begin
            data_next = wdata_i;
        end
        if (wr_i && hit(addr_i, `CONV_CONTROL_OFFSET)) begin
            enable_next = wdata_i[`CONV_ENABLE_BIT];
        end
    end

    // read data valid the cycle after the strobe; unmapped reads zero
    always_comb begin
        rdata_next = 8'h00;
        if (rd_i && hit(addr_i, `CONV_CONTROL_OFFSET)) begin
            rdata_next = {7'h00, enable_reg};
        end else if (rd_i && hit(addr_i, `CONV_DATA_OFFSET)) begin
            rdata_next = data_reg;
        end
    end

    // pin mode: halt opens the output even when enabled
    always_comb begin
        if (halt_i) begin
            mode_next = PIN_OPEN;
        end else if (enable_next) begin
            mode_next = PIN_DRIVE;
        end else begin
            mode_next = PIN_INPUT;
        end
    end

    // pin controls follow the mode; enable overrides the port direction
    always_comb begin
        dir_next  = gpio_dir_out_i;
        dout_next = gpio_out_i;
        doe_next  = gpio_dir_out_i;
        gin_next  = shared_analog_pin_i;
        drive_next = (mode_next == PIN_DRIVE);
        case (mode_next)
            PIN_DRIVE: begin
                dir_next = 1'b1;
                doe_next = 1'b0;
            end
            PIN_OPEN: begin
                dir_next = enable_next || gpio_dir_out_i;
                doe_next = 1'b0;
                gin_next = 1'b0;
            end
            PIN_INPUT: begin
                dir_next = gpio_dir_out_i;
            end
            default: begin
                dir_next = gpio_dir_out_i;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_reg   <= `CONV_DATA_RESET;
            enable_reg <= CTRL_RESET[`CONV_ENABLE_BIT];
            rdata_reg  <= 8'h00;
            drive_reg  <= 1'b0;
            gin_reg    <= 1'b0;
            dir_reg    <= 1'b0;
            dout_reg   <= 1'b0;
            doe_reg    <= 1'b0;
        end else begin
            data_reg   <= data_next;
            enable_reg <= enable_next;
            rdata_reg  <= rdata_next;
            drive_reg  <= drive_next;
            gin_reg    <= gin_next;
            dir_reg    <= dir_next;
            dout_reg   <= dout_next;
            doe_reg    <= doe_next;
        end
    end

    // the ladder maps code n to n/256 of the span; code passes unchanged
    assign ladder_code_o     = data_reg;
    assign ladder_drive_o    = drive_reg;
    assign pin_dir_out_o     = dir_reg;
    assign pin_digital_out_o = dout_reg;
    assign pin_digital_oe_o  = doe_reg;
    assign gpio_in_o         = gin_reg;
    assign rdata_o           = rdata_reg;

    // status only; software still owns the wait
    settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .start_i   (wr_i && hit(addr_i, `CONV_DATA_OFFSET)),
        .settled_o (settled)
    );
    assign code_settled_o = settled;

    sequence s_data_write;
        wr_i && addr_i == `CONV_DATA_OFFSET;
    endsequence

    a_data_store: assert property (@(posedge clk_i) disable iff (rst_i)
        s_data_write |=> ladder_code_o == $past(wdata_i))
        else $error("code register did not take the write");

    a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_i && addr_i == `CONV_CONTROL_OFFSET |=> enable_reg == $past(wdata_i[0]))
        else $error("control write not accepted");

    a_ctrl_read: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == `CONV_CONTROL_OFFSET |=> rdata_o[7:1] == 7'h00 && rdata_o[0] == $past(enable_reg))
        else $error("control read upper bits not zero");

    a_halt_open: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_i |=> !ladder_drive_o)
        else $error("output driven during halt");

    a_drive_on: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_next && !halt_i |=> ladder_drive_o && pin_dir_out_o && !pin_digital_oe_o)
        else $error("enabled output not driven");

    a_input_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !enable_next && !halt_i |=> !ladder_drive_o && gpio_in_o == $past(shared_analog_pin_i))
        else $error("disabled pin not a plain input");

    a_force_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_reg && !gpio_dir_out_i ##1 enable_reg |-> pin_dir_out_o)
        else $error("enable did not force output direction");

    a_code_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_i && addr_i == `CONV_DATA_OFFSET) |=> $stable(ladder_code_o))
        else $error("ladder code changed without a data write");
endmodule : dac_control_interface
`default_nettype wire

/* shared/dac_consts.svh */
/*
 * Constants for the converter control block: register offsets, field positions,
 * reset values and timing counts.
 * Assumes a 125 MHz bus clock and byte-wide register port.
 */
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

`define CONV_CONTROL_OFFSET 8'h7d
`define CONV_DATA_OFFSET    8'h7e
`define CONV_CONTROL_RESET  8'h00
`define CONV_DATA_RESET     8'h00
`define CONV_ENABLE_BIT     0
`define CLK_PERIOD_NS       8
`define SETTLE_TIME_NS      5000
`define SETTLE_CYCLES       ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* shared/dac_pkg.sv */
/*
 * Types shared by the converter control block.
 * Assumes nothing beyond the constants header.
 */
`default_nettype none
package dac_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        PIN_INPUT,
        PIN_DRIVE,
        PIN_OPEN
    } pin_mode_e;
endpackage : dac_pkg
`default_nettype wire

/* rtl/settle_timer.sv */
/*
 * Settling timer: counts down after each code write, flags when settled.
 * Assumes a synchronous active-high reset and one clock.
 */
`include "dac_consts.svh"
`default_nettype none
module settle_timer
    import dac_pkg::*;
#(
    parameter int CYCLES = `SETTLE_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    output var  logic settled_o
);
    localparam int W = $clog2(CYCLES + 1);

    // fewer cycles than the bound checked below cannot serve a real settle wait
    if (CYCLES < 8) begin : g_bad_cycles
        $error("settle_timer: CYCLES must be at least 8");
    end

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic         settled_reg;
    logic         settled_next;

    // restart on every write; otherwise run down to zero
    always_comb begin
        count_next = count_reg;
        if (start_i) begin
            count_next = W'(CYCLES);
        end else if (count_reg != '0) begin
            count_next = count_reg - W'(1);
        end
        settled_next = (count_next == '0);
    end

    // flag registered so the status output comes straight from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg   <= '0;
            settled_reg <= 1'b1;
        end else begin
            count_reg   <= count_next;
            settled_reg <= settled_next;
        end
    end

    assign settled_o = settled_reg;

    a_settle_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        start_i |=> !settled_o [*8])
        else $error("settled flag rose too early after write");
endmodule : settle_timer
`default_nettype wire

/* sim/pin_partner.sv */
/*
 * Outside circuitry on the shared pin: a weak source the bench sets.
 * Assumes the block's digital driver controls arrive as plain levels.
 */
`default_nettype none
module pin_partner (
    input  wire logic ext_level_i,
    input  wire logic dig_oe_i,
    input  wire logic dig_out_i,
    output var  logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // the port driver overpowers the weak outside source when on
    always_comb begin
        if (dig_oe_i) begin
            pin_o = dig_out_i;
        end else begin
            pin_o = ext_level_i;
        end
    end
endmodule : pin_partner
`default_nettype wire

/* sim/tb.sv */
/*
 * Register and pin tests for the converter control block.
 * Assumes the byte register port with read data one cycle after the strobe.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 10;
    logic       clk_i, rst_i, wr_i, rd_i, halt_i, gdir, gout, ext, pin;
    logic [7:0] addr_i, wdata_i, rdata_o, code;
    logic       gin, drive, dir, dout, doe, settled;
    logic [7:0] codes [4] = '{8'h00, 8'hff, 8'h80, 8'h01};
    int         failures, checked, cycles;

    dac_control_interface #(.SETTLE_CYCLES(SETTLE)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i),
        .gpio_dir_out_i(gdir), .gpio_out_i(gout), .shared_analog_pin_i(pin),
        .gpio_in_o(gin), .ladder_code_o(code), .ladder_drive_o(drive),
        .pin_dir_out_o(dir), .pin_digital_out_o(dout), .pin_digital_oe_o(doe),
        .code_settled_o(settled));
    pin_partner u_pin (.ext_level_i(ext), .dig_oe_i(doe), .dig_out_i(dout), .pin_o(pin));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one-cycle strobes, released at the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(what, exp, rdata_o);
    endtask : rd

    task automatic wait_cy(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cy

    task automatic report_and_stop();
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // hang guard, well above the roughly 80 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("Error timeout expected done seen hang");
            report_and_stop();
        end
    end

    initial begin
        {rst_i, wr_i, rd_i, halt_i, gdir, gout, ext} = 7'h40;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk("settled", 1, settled);
        rd(8'h7d, 8'h00, "control reset");
        rd(8'h7e, 8'h00, "data reset");
        chk("drive", 0, drive);
        // end codes of the range and the midpoint
        foreach (codes[i]) begin
            wr(8'h7e, codes[i]);
            chk("code", codes[i], code);
            rd(8'h7e, codes[i], "data");
        end
        // settle flag low for exactly the settle count after a write
        wr(8'h7e, 8'ha5);
        wait_cy(SETTLE - 1);
        chk("settled", 0, settled);
        wait_cy(1); // software waits out the settle time
        chk("settled", 1, settled);
        @(posedge clk_i);
        ext <= 1'b1;
        wr(8'h7d, 8'hff);
        rd(8'h7d, 8'h01, "control");
        wait_cy(1);
        chk("rdata idle", 8'h00, rdata_o);
        wait_cy(1);
        chk("drive", 1, drive);
        chk("dir", 1, dir);
        chk("oe", 0, doe);
        chk("code", 8'ha5, code);
        // halt opens the output but keeps the enable and forced direction
        @(posedge clk_i);
        halt_i <= 1'b1;
        wait_cy(3);
        chk("drive", 0, drive);
        chk("oe", 0, doe);
        chk("dir", 1, dir);
        chk("gin", 0, gin);
        rd(8'h7d, 8'h01, "control in halt");
        @(posedge clk_i);
        halt_i <= 1'b0;
        wait_cy(3);
        chk("drive", 1, drive);
        wr(8'h7d, 8'h00);
        wait_cy(3);
        chk("drive", 0, drive);
        chk("dir", 0, dir);
        chk("gin", 1, gin);
        @(posedge clk_i);
        ext <= 1'b0;
        gdir <= 1'b1;
        gout <= 1'b1;
        wait_cy(3);
        chk("oe", 1, doe);
        chk("dout", 1, dout);
        chk("gin", 1, gin);
        wr(8'h7d, 8'h01);
        wait_cy(2);
        chk("oe", 0, doe);
        rd(8'h7f, 8'h00, "unmapped");
        // write then read with no gap between the strobes
        @(posedge clk_i);
        addr_i <= 8'h7e;
        wdata_i <= 8'h3c;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("data back to back", 8'h3c, rdata_o);
        // reset in mid-run brings registers and pin controls back
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk("code", 8'h00, code);
        chk("drive", 0, drive);
        chk("settled", 1, settled);
        rd(8'h7d, 8'h00, "control reset");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
